// >>> hdl/elapsed_counter_map.svh
// Constants of the elapsed-time counter: widths, codes, timing counts.
// Assumes inclusion by hdl and test files; definitions only.
`ifndef ELAPSED_COUNTER_MAP_SVH
`define ELAPSED_COUNTER_MAP_SVH

`define CNT_WIDTH          40
`define CNT_RESET          40'h00_0000_0000
`define DIV_PLL3           5'h08
`define DIV_PLL2           5'h14
`define DIV_WIDTH          5
`define SEL_PLL3           1'b0
`define SEL_PLL2           1'b1
`define TRIG_SEL_PIN       1'b1
`define TRIG_SEL_CS        1'b0
`define PIN_FUNC_TRIGGER   6'h27
`define PIN_FUNC_WIDTH     6

`endif

// >>> hdl/elapsed_counter_pkg.sv
// Types of the elapsed-time counter.
// Assumes the map header for all numbers.
package elapsed_counter_pkg;
    typedef enum logic [1:0] {
        ARM_READY,
        ARM_WAIT_MSB_DONE,
        ARM_WAIT_LSB
    } arm_state_t;
endpackage

// >>> hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes clk_sys domain; input is asynchronous.
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;

    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end
endmodule

// >>> hdl/time_elapsed_counter.sv
// Forty-bit elapsed-time counter with capture on chip-select or pin edge.
// Assumes clk_sys at 40 MHz; VCO ticks and pins arrive asynchronously.
//
// Summary of operation
// - Source select 0 picks PLL3 VCO tick, 1 picks PLL2 VCO tick.
// - PLL3 source: counter advances once every eight VCO ticks.
// - PLL2 source: counter advances once every twenty VCO ticks.
// - Trigger source 1 selects pin trigger, 0 selects chip-select trigger.
// - Counting runs only with enable bit written to one.
// - Chip-select falling edge captures running count while enabled and armed.
// - After MSB read, chip-select edges ignored until LSB is read.
// - One multibyte burst may both capture and re-arm capture.
// - Pin with function 0x27 triggers capture on polarity-selected edge.
// - After pin capture, pin edges ignored until LSB is read.
// - Captured count is forty bits, read as byte-wide registers.
// - Counter wraps from all ones to zero without any flag.
// - Enable low holds counter at zero; counting starts from zero.
// - Clear control must be zero for counting.
// - Source select also drives the reference validator VCO choice.
// - Enable rising edge starts an absolute measurement from zero.
`timescale 1ns/1ps
`include "elapsed_counter_map.svh"
module time_elapsed_counter
    import elapsed_counter_pkg::*;
(
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         pll3_vco_tick,
    input  wire logic                         pll2_vco_tick,
    input  wire logic                         counter_vco_source_select,
    input  wire logic                         capture_trigger_source,
    input  wire logic                         elapsed_counter_enable,
    input  wire logic                         counter_clear_control,
    input  wire logic                         serial_chip_select_n,
    input  wire logic                         trigger_pin,
    input  wire logic [`PIN_FUNC_WIDTH-1:0]   pin_function_select,
    input  wire logic                         pin_polarity_invert,
    input  wire logic                         read_msb_strobe,
    input  wire logic                         read_lsb_strobe,
    output logic      [`CNT_WIDTH-1:0]        captured_count_field,
    output logic                              capture_armed,
    output logic                              validator_vco_select
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic pll3_lvl;
    logic pll2_lvl;
    logic cs_lvl;
    logic pin_lvl;

    pin_sync u_sync_pll3 (.clk_sys(clk_sys), .rst(rst), .pin_in(pll3_vco_tick),
        .level_q(pll3_lvl));
    pin_sync u_sync_pll2 (.clk_sys(clk_sys), .rst(rst), .pin_in(pll2_vco_tick),
        .level_q(pll2_lvl));
    pin_sync u_sync_cs (.clk_sys(clk_sys), .rst(rst), .pin_in(serial_chip_select_n),
        .level_q(cs_lvl));
    pin_sync u_sync_pin (.clk_sys(clk_sys), .rst(rst), .pin_in(trigger_pin),
        .level_q(pin_lvl));

    // ************************************************************
    // Edge detection
    // ************************************************************
    logic pll3_prev_q;
    logic pll2_prev_q;
    logic cs_prev_q;
    logic pin_prev_q;
    logic vco_rise;
    logic cs_fall;
    logic pin_edge;
    logic pin_is_trigger;

    assign vco_rise = (counter_vco_source_select == `SEL_PLL2)
                    ? (pll2_lvl & ~pll2_prev_q) : (pll3_lvl & ~pll3_prev_q);
    assign cs_fall  = cs_prev_q & ~cs_lvl;
    assign pin_is_trigger = (pin_function_select == `PIN_FUNC_TRIGGER);
    assign pin_edge = pin_polarity_invert ? (pin_prev_q & ~pin_lvl)
                                          : (~pin_prev_q & pin_lvl);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pll3_prev_q <= 1'b0;
            pll2_prev_q <= 1'b0;
            cs_prev_q   <= 1'b0;
            pin_prev_q  <= 1'b0;
        end else begin
            pll3_prev_q <= pll3_lvl;
            pll2_prev_q <= pll2_lvl;
            cs_prev_q   <= cs_lvl;
            pin_prev_q  <= pin_lvl;
        end
    end

    // ************************************************************
    // Prescaler and counter
    // ************************************************************
    logic [`DIV_WIDTH-1:0] div_q;
    logic [`DIV_WIDTH-1:0] div_d;
    logic [`DIV_WIDTH-1:0] div_last;
    logic                  cnt_en;
    logic [`CNT_WIDTH-1:0] cnt_q;
    logic [`CNT_WIDTH-1:0] cnt_d;
    logic                  run;

    assign div_last = (counter_vco_source_select == `SEL_PLL2)
                    ? (`DIV_PLL2 - 5'h01) : (`DIV_PLL3 - 5'h01);
    assign run = elapsed_counter_enable & ~counter_clear_control;

    always_comb begin
        div_d  = div_q;
        cnt_en = 1'b0;
        cnt_d  = cnt_q;
        if (!run) begin
            div_d = '0;
            cnt_d = `CNT_RESET;
        end else if (vco_rise) begin
            if (div_q >= div_last) begin
                div_d  = '0;
                cnt_en = 1'b1;
            end else begin
                div_d = div_q + 5'h01;
            end
        end
        if (cnt_en) begin
            cnt_d = cnt_q + 40'h00_0000_0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            cnt_q <= `CNT_RESET;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // Capture and arming
    // ************************************************************
    arm_state_t            arm_q;
    arm_state_t            arm_d;
    logic [`CNT_WIDTH-1:0] cap_d;
    logic                  cs_trig;
    logic                  pin_trig;
    logic                  armed_d;
    logic                  vsel_d;

    assign cs_trig  = (capture_trigger_source == `TRIG_SEL_CS) & cs_fall;
    assign pin_trig = (capture_trigger_source == `TRIG_SEL_PIN) & pin_is_trigger & pin_edge;

    always_comb begin
        arm_d = arm_q;
        cap_d = captured_count_field;
        case (arm_q)
            ARM_READY: begin
                if (elapsed_counter_enable && cs_trig) begin
                    cap_d = cnt_q;
                end
                if (read_msb_strobe && capture_trigger_source == `TRIG_SEL_CS) begin
                    arm_d = ARM_WAIT_LSB;
                end
                if (read_lsb_strobe) begin
                    arm_d = ARM_READY;
                end
                if (elapsed_counter_enable && pin_trig) begin
                    cap_d = cnt_q;
                    arm_d = ARM_WAIT_LSB;
                end
            end
            ARM_WAIT_LSB: begin
                if (read_lsb_strobe) begin
                    arm_d = ARM_READY;
                end
            end
            default: begin
                arm_d = ARM_READY;
            end
        endcase
        // Disabled block always rearms
        if (!elapsed_counter_enable) begin
            arm_d = ARM_READY;
        end
    end

    assign armed_d = (arm_d == ARM_READY);
    assign vsel_d  = counter_vco_source_select;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arm_q                <= ARM_READY;
            captured_count_field <= `CNT_RESET;
            capture_armed        <= 1'b1;
            validator_vco_select <= `SEL_PLL3;
        end else begin
            arm_q                <= arm_d;
            captured_count_field <= cap_d;
            capture_armed        <= armed_d;
            validator_vco_select <= vsel_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [`DIV_WIDTH-1:0] edge_seen_q;
    logic [`DIV_WIDTH-1:0] edge_seen_d;
    logic                  switched_q;
    logic                  switched_d;

    always_comb begin
        edge_seen_d = edge_seen_q;
        switched_d  = switched_q;
        if (!run || cnt_en) begin
            edge_seen_d = '0;
            switched_d  = 1'b0;
        end else if (vco_rise) begin
            edge_seen_d = edge_seen_q + 5'h01;
        end
        // Source change voids one ratio check
        if (run && counter_vco_source_select != validator_vco_select) begin
            switched_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            edge_seen_q <= '0;
            switched_q  <= 1'b0;
        end else begin
            edge_seen_q <= edge_seen_d;
            switched_q  <= switched_d;
        end
    end

    hold_zero_a: assert property (!run |=> cnt_q == '0)
        else $error("Counter not held at zero");
    step_one_a: assert property (cnt_en |=> cnt_q == $past(cnt_q) + 40'h1)
        else $error("Counter step wrong");
    no_step_a: assert property (run && !cnt_en |=> cnt_q == $past(cnt_q))
        else $error("Counter moved without prescale");
    pin_block_a: assert property (arm_q == ARM_WAIT_LSB && !read_lsb_strobe
        |=> captured_count_field == $past(captured_count_field))
        else $error("Capture while blocked");
    cs_cap_a: assert property (arm_q == ARM_READY && elapsed_counter_enable
        && cs_trig |=> captured_count_field == $past(cnt_q))
        else $error("Chip-select capture missed");
    unsel_a: assert property (!cs_trig && !pin_trig
        |=> captured_count_field == $past(captured_count_field))
        else $error("Capture without selected trigger");
    rearm_a: assert property (read_lsb_strobe && elapsed_counter_enable
        && !(arm_q == ARM_READY && pin_trig) |=> capture_armed)
        else $error("LSB read did not rearm");
    msb_block_a: assert property (arm_q == ARM_READY && read_msb_strobe
        && !read_lsb_strobe && elapsed_counter_enable
        && capture_trigger_source == `TRIG_SEL_CS |=> !capture_armed)
        else $error("MSB read did not block");
    vsel_a: assert property (##1
        validator_vco_select == $past(counter_vco_source_select))
        else $error("Validator select lag");
    pin_cap_a: assert property (arm_q == ARM_READY && elapsed_counter_enable
        && pin_trig |=> captured_count_field == $past(cnt_q) && !capture_armed)
        else $error("Pin capture missed");
    trig_sel_a: assert property (capture_trigger_source == `TRIG_SEL_PIN
        && cs_fall && !pin_trig |=> $stable(captured_count_field))
        else $error("Chip-select edge captured in pin mode");
    src_sel_a: assert property (run && counter_vco_source_select == `SEL_PLL2
        && !(pll2_lvl && !pll2_prev_q) |=> cnt_q == $past(cnt_q))
        else $error("Counter moved without selected VCO");
    clear_hold_a: assert property (counter_clear_control |=> cnt_q == '0)
        else $error("Clear control did not hold counter");
    en_arm_a: assert property (!elapsed_counter_enable |=> capture_armed)
        else $error("Disabled block not armed");
    start_zero_a: assert property ($rose(run) |-> cnt_q == '0)
        else $error("Count did not start from zero");
    div_ratio_a: assert property (cnt_en && !switched_q
        && counter_vco_source_select == validator_vco_select
        |-> edge_seen_q == ((counter_vco_source_select == `SEL_PLL2)
        ? (`DIV_PLL2 - 5'h01) : (`DIV_PLL3 - 5'h01)))
        else $error("Prescale ratio wrong");

    cs_capture_c: cover property (arm_q == ARM_READY && elapsed_counter_enable && cs_trig);
    pin_capture_c: cover property (arm_q == ARM_READY && elapsed_counter_enable && pin_trig);
    burst_c: cover property (read_msb_strobe ##[1:20] read_lsb_strobe);
    wrap_c: cover property (cnt_en && cnt_q == '1);
    pin_blocked_c: cover property (arm_q == ARM_WAIT_LSB && pin_is_trigger && pin_edge);

endmodule

// >>> test/host_model.sv
// Host stand-in: serial frames with read strobes, and the trigger pin.
// Assumes clk_sys from the bench; all drives on rising edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_sys,
    output logic      serial_chip_select_n,
    output logic      trigger_pin,
    output logic      read_msb_strobe,
    output logic      read_lsb_strobe
);
    // ****
    // Idle levels
    // ****
    initial begin
        serial_chip_select_n = 1'b1;
        trigger_pin = 1'b0;
        read_msb_strobe = 1'b0;
        read_lsb_strobe = 1'b0;
    end
    task automatic pulse_read(input bit lsb);
        @(posedge clk_sys);
        read_msb_strobe <= !lsb;
        read_lsb_strobe <= lsb;
        @(posedge clk_sys);
        read_msb_strobe <= 1'b0;
        read_lsb_strobe <= 1'b0;
    endtask
    // ****
    // Serial frame
    // ****
    task automatic frame(input bit msb, input bit lsb);
        @(posedge clk_sys);
        serial_chip_select_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        if (msb) pulse_read(1'b0);
        if (lsb) pulse_read(1'b1);
        repeat (4) @(posedge clk_sys);
        serial_chip_select_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        if (lsb) repeat (40) @(posedge clk_sys);
    endtask
    // Pin moves a cycle after any write
    task automatic pin_set(input logic v);
        @(posedge clk_sys);
        trigger_pin <= v;
        repeat (12) @(posedge clk_sys);
    endtask
endmodule

// >>> test/time_elapsed_counter_tb.sv
// Bench for the elapsed-time counter, with an integer model of the count.
// Assumes the map header on the include path and host_model compiled first.
`timescale 1ns/1ps
`include "elapsed_counter_map.svh"
module time_elapsed_counter_tb;
    logic clk_sys, rst, pll3_vco_tick, pll2_vco_tick;
    logic counter_vco_source_select, capture_trigger_source;
    logic elapsed_counter_enable, counter_clear_control;
    logic [5:0] pin_function_select;
    logic pin_polarity_invert;
    logic serial_chip_select_n, trigger_pin, read_msb_strobe, read_lsb_strobe;
    logic capture_armed, validator_vco_select;
    logic [39:0] captured_count_field;
    logic [39:0] exp_cap = 40'h0;
    int failures = 0;
    int checked = 0;
    int t2 = 0;
    int t3 = 0;
    logic [31:0] seed = 32'h11;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    time_elapsed_counter dut_u (.clk_sys, .rst, .pll3_vco_tick, .pll2_vco_tick,
        .counter_vco_source_select, .capture_trigger_source, .elapsed_counter_enable,
        .counter_clear_control, .serial_chip_select_n, .trigger_pin, .pin_function_select,
        .pin_polarity_invert, .read_msb_strobe, .read_lsb_strobe, .captured_count_field,
        .capture_armed, .validator_vco_select);
    host_model host_u (.clk_sys, .serial_chip_select_n, .trigger_pin, .read_msb_strobe,
        .read_lsb_strobe);
    // ****
    // Helpers
    // ****
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 20 + int'(seed % 60);
    endfunction
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ticks(input bit pll2, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            if (pll2) pll2_vco_tick <= 1'b1;
            else pll3_vco_tick <= 1'b1;
            repeat (2) @(posedge clk_sys);
            pll2_vco_tick <= 1'b0;
            pll3_vco_tick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        if (elapsed_counter_enable && !counter_clear_control) begin
            if (pll2) t2 += n;
            else t3 += n;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    // Expected capture: taken or unchanged, then armed flag
    task automatic expect_cap(input bit takes, input logic arm);
        if (takes) exp_cap = counter_clear_control ? 40'h0 :
            (counter_vco_source_select ? 40'(t2 / 20) : 40'(t3 / 8));
        check("captured", captured_count_field, exp_cap);
        check("armed", {39'h0, capture_armed}, {39'h0, arm});
    endtask
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end
    initial begin
        rst <= 1'b1;
        pll3_vco_tick <= 1'b0;
        pll2_vco_tick <= 1'b0;
        counter_vco_source_select <= `SEL_PLL3;
        capture_trigger_source <= `TRIG_SEL_CS;
        elapsed_counter_enable <= 1'b0;
        counter_clear_control <= 1'b0;
        pin_function_select <= `PIN_FUNC_TRIGGER;
        pin_polarity_invert <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        elapsed_counter_enable <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ticks(1'b0, rnd());
        ticks(1'b1, rnd());
        check("vco_sel", {39'h0, validator_vco_select}, 40'h0);
        host_u.frame(1'b0, 1'b0);
        expect_cap(1'b1, 1'b1);
        $display("test cs capture done");
        ticks(1'b0, rnd());
        host_u.frame(1'b1, 1'b0);
        expect_cap(1'b1, 1'b0);
        ticks(1'b0, rnd());
        host_u.frame(1'b0, 1'b0);
        expect_cap(1'b0, 1'b0);
        host_u.frame(1'b0, 1'b1);
        expect_cap(1'b0, 1'b1);
        ticks(1'b0, rnd());
        host_u.frame(1'b1, 1'b1);
        expect_cap(1'b1, 1'b1);
        host_u.pin_set(1'b1);
        host_u.pin_set(1'b0);
        expect_cap(1'b0, 1'b1);
        $display("test cs blocking done");
        capture_trigger_source <= `TRIG_SEL_PIN;
        ticks(1'b0, rnd());
        host_u.frame(1'b0, 1'b0);
        expect_cap(1'b0, 1'b1);
        host_u.pin_set(1'b1);
        expect_cap(1'b1, 1'b0);
        ticks(1'b0, rnd());
        pin_polarity_invert <= 1'b1;
        host_u.pin_set(1'b0);
        expect_cap(1'b0, 1'b0);
        host_u.frame(1'b0, 1'b1);
        host_u.pin_set(1'b1);
        expect_cap(1'b0, 1'b1);
        ticks(1'b0, rnd());
        host_u.pin_set(1'b0);
        expect_cap(1'b1, 1'b0);
        pin_function_select <= `PIN_FUNC_TRIGGER ^ 6'(rnd() % 63 + 1);
        host_u.frame(1'b0, 1'b1);
        ticks(1'b0, rnd());
        host_u.pin_set(1'b1);
        host_u.pin_set(1'b0);
        expect_cap(1'b0, 1'b1);
        $display("test pin trigger done");
        elapsed_counter_enable <= 1'b0;
        counter_vco_source_select <= `SEL_PLL2;
        pin_polarity_invert <= 1'b0;
        pin_function_select <= `PIN_FUNC_TRIGGER;
        ticks(1'b1, 30);
        check("vco_sel", {39'h0, validator_vco_select}, 40'h1);
        t2 = 0;
        t3 = 0;
        elapsed_counter_enable <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ticks(1'b1, rnd() + 40);
        ticks(1'b0, rnd());
        host_u.pin_set(1'b1);
        expect_cap(1'b1, 1'b0);
        host_u.pin_set(1'b0);
        host_u.frame(1'b0, 1'b1);
        counter_clear_control <= 1'b1;
        ticks(1'b1, 45);
        host_u.pin_set(1'b1);
        expect_cap(1'b1, 1'b0);
        $display("test pll2 and clear done");
        wrap_up();
    end
endmodule
